// [hdl/vpp_map.svh]
// Register offsets, field positions, reset values and packet codes
`ifndef VPP_MAP_SVH
`define VPP_MAP_SVH
`define VPP_OFF_CTRL      12'h000
`define VPP_OFF_GAP       12'h004
`define VPP_OFF_STATUS    12'h008
`define VPP_OFF_WIDTH     12'h00c
`define VPP_OFF_HEIGHT    12'h010
`define VPP_OFF_INTL      12'h014
`define VPP_OFF_VIDCNT    12'h018
`define VPP_OFF_CTLCNT    12'h01c
`define VPP_OFF_ANCCNT    12'h020
`define VPP_OFF_OTHCNT    12'h024
`define VPP_OFF_MISSCNT   12'h028
`define VPP_CTRL_EN_BIT   0
`define VPP_CTRL_RST      1'b1
`define VPP_GAP_RST       16'h0000
`define VPP_ST_INPKT_BIT  0
`define VPP_ST_PEND_BIT   1
`define VPP_ST_KIND_LSB   4
`define VPP_ST_LEVEL_LSB  8
`define VPP_TYPE_VIDEO    4'h0
`define VPP_TYPE_CTRL     4'hf
`define VPP_TYPE_ANC_DEF  4'hc
`define VPP_NIB_BITS      4
`define VPP_NIB_TOTAL     4'h9
`define VPP_ANC_CODE0     32'h0000_0000
`define VPP_ANC_CODE1     32'h0000_03ff
`define VPP_READY_LAT     1
`endif

// [hdl/vpp_pkg.sv]
// Types shared by the video packet port
package vpp_pkg;
    typedef enum logic [2:0] {
        KIND_IDLE,
        KIND_VIDEO,
        KIND_CTRL,
        KIND_ANC,
        KIND_OTHER
    } vpp_kind_t;
endpackage : vpp_pkg

// [hdl/vpp_beat_mem.sv]
// Beat store with registered read data
`timescale 1ns/1ps
module vpp_beat_mem #(
    parameter int WIDTH = 22,
    parameter int DEPTH = 8,
    parameter int AW    = 3
) (
    input  wire logic             clk,
    input  wire logic             wr_en,
    input  wire logic [AW-1:0]    wr_addr,
    input  wire logic [WIDTH-1:0] wr_data,
    input  wire logic             rd_en,
    input  wire logic [AW-1:0]    rd_addr,
    output logic      [WIDTH-1:0] rd_data
);
    logic [WIDTH-1:0] mem [DEPTH];

    always_ff @(posedge clk)
    begin
        if (wr_en)
        begin
            mem[wr_addr] <= wr_data;
        end
    end

    // Read data held until the next read, so the output stays stable under stall
    always_ff @(posedge clk)
    begin
        if (rd_en)
        begin
            rd_data <= mem[rd_addr];
        end
    end
endmodule : vpp_beat_mem

// [hdl/vpp_packet_port.sv]
// Video packet port: forwards packets din to dout with width conversion
`timescale 1ns/1ps
`include "vpp_map.svh"
module vpp_packet_port #(
    parameter int         IN_BPS   = 10,
    parameter int         OUT_BPS  = 10,
    parameter int         SYMS     = 2,
    parameter int         DEPTH    = 8,
    parameter logic [3:0] ANC_TYPE = `VPP_TYPE_ANC_DEF
) (
    input  wire logic                    clk,
    input  wire logic                    rst_n,
    input  wire logic                    psel,
    input  wire logic                    penable,
    input  wire logic                    pwrite,
    input  wire logic [11:0]             paddr,
    input  wire logic [31:0]             pwdata,
    output logic      [31:0]             prdata,
    output logic                         pready,
    output logic                         pslverr,
    input  wire logic                    din_valid,
    input  wire logic [IN_BPS*SYMS-1:0]  din_data,
    input  wire logic                    din_sop,
    input  wire logic                    din_eop,
    output logic                         din_ready,
    output logic                         dout_valid,
    output logic [OUT_BPS*SYMS-1:0]      dout_data,
    output logic                         dout_sop,
    output logic                         dout_eop,
    input  wire logic                    dout_ready,
    output vpp_pkg::vpp_kind_t           pkt_kind
);
    import vpp_pkg::*;

    localparam int IW = IN_BPS * SYMS;
    localparam int OW = OUT_BPS * SYMS;
    localparam int MW = OW + 2;
    localparam int AW = $clog2(DEPTH);
    localparam int CW = AW + 1;
    localparam logic [CW-1:0] HI_MARK = CW'(DEPTH - 2 - `VPP_READY_LAT);

    logic            din_ready_q;
    logic            rdy_seen_q;
    logic            dout_valid_q;
    vpp_kind_t       kind_q;
    vpp_kind_t       kind_now;
    logic            accept;
    logic            body;
    logic            ctrl_en_q;
    logic [15:0]     gap_cfg_q;
    logic [15:0]     gap_q;
    logic [AW-1:0]   wr_ptr_q;
    logic [AW-1:0]   rd_ptr_q;
    logic [CW-1:0]   count_q;
    logic            rd_en;
    logic [MW-1:0]   wr_word;
    logic [MW-1:0]   rd_word;
    logic [3:0]      nib_q;
    logic [3:0]      nib_d;
    logic [15:0]     pw_q;
    logic [15:0]     pw_d;
    logic [15:0]     ph_q;
    logic [15:0]     ph_d;
    logic [3:0]      pi_q;
    logic [3:0]      pi_d;
    logic            pend_q;
    logic [15:0]     pend_w_q;
    logic [15:0]     pend_h_q;
    logic [3:0]      pend_i_q;
    logic [15:0]     act_w_q;
    logic [15:0]     act_h_q;
    logic [3:0]      act_i_q;
    logic [1:0]      hist_q;
    logic [1:0]      hist_d;
    logic [15:0]     anc_hits;
    logic [15:0]     vid_cnt_q;
    logic [15:0]     ctl_cnt_q;
    logic [15:0]     anc_cnt_q;
    logic [15:0]     oth_cnt_q;
    logic [15:0]     miss_cnt_q;
    logic            bus_do;
    logic            bus_hit;
    logic [31:0]     bus_rd;

    function automatic vpp_kind_t kind_of(input logic [3:0] t);
        if (t == `VPP_TYPE_VIDEO)
            return KIND_VIDEO;
        else if (t == `VPP_TYPE_CTRL)
            return KIND_CTRL;
        else if (t == ANC_TYPE)
            return KIND_ANC;
        else
            return KIND_OTHER;
    endfunction : kind_of

    // Video keeps the MSBs, other symbols keep the LSBs
    function automatic logic [OW-1:0] conv_beat(input logic [IW-1:0] d, input logic vid);
        logic [OW-1:0] r;
        int            idx;
        r = '0;
        for (int s = 0; s < SYMS; s++)
        begin
            for (int b = 0; b < OUT_BPS; b++)
            begin
                idx = vid ? b + IN_BPS - OUT_BPS : b;
                if (idx >= 0 && idx < IN_BPS)
                    r[s*OUT_BPS+b] = d[s*IN_BPS+idx];
            end
        end
        return r;
    endfunction : conv_beat

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            rdy_seen_q <= 1'b0;
        else
            rdy_seen_q <= din_ready_q;
    end

    assign accept   = din_valid & rdy_seen_q;
    assign kind_now = din_sop ? kind_of(din_data[3:0]) : kind_q;
    assign body     = accept & ~din_sop;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            kind_q <= KIND_IDLE;
        else if (accept && din_eop)
            kind_q <= KIND_IDLE;
        else if (accept && din_sop)
            kind_q <= kind_now;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            pkt_kind <= KIND_IDLE;
        else
            pkt_kind <= kind_q;
    end

    assign wr_word = {din_sop, din_eop,
                      conv_beat(din_data, body && kind_q == KIND_VIDEO)};

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            gap_q <= 16'h0000;
        else if (accept && din_eop && kind_now == KIND_VIDEO)
            gap_q <= gap_cfg_q;
        else if (gap_q != 16'h0000)
            gap_q <= gap_q - 16'h0001;
    end

    // Margin covers the beats already in flight under the ready latency
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            din_ready_q <= 1'b0;
        else
            din_ready_q <= ctrl_en_q && gap_q == 16'h0000 && count_q <= HI_MARK;
    end
    assign din_ready = din_ready_q;

    // Read only when sink was ready
    assign rd_en = (count_q != '0) & dout_ready;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q  <= '0;
        end
        else
        begin
            if (accept)
                wr_ptr_q <= wr_ptr_q + AW'(1);
            if (rd_en)
                rd_ptr_q <= rd_ptr_q + AW'(1);
            count_q <= count_q + CW'(accept) - CW'(rd_en);
        end
    end

    vpp_beat_mem #(
        .WIDTH (MW),
        .DEPTH (DEPTH),
        .AW    (AW)
    ) u_mem (
        .clk     (clk),
        .wr_en   (accept),
        .wr_addr (wr_ptr_q),
        .wr_data (wr_word),
        .rd_en   (rd_en),
        .rd_addr (rd_ptr_q),
        .rd_data (rd_word)
    );

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            dout_valid_q <= 1'b0;
        else
            dout_valid_q <= rd_en;
    end
    assign dout_valid = dout_valid_q;
    // Parallelism kept, last beat already full
    assign dout_data  = rd_word[OW-1:0];
    assign dout_eop   = rd_word[OW];
    assign dout_sop   = rd_word[OW+1];

    always_comb
    begin
        nib_d = nib_q;
        pw_d  = pw_q;
        ph_d  = ph_q;
        pi_d  = pi_q;
        if (body && kind_q == KIND_CTRL)
        begin
            for (int s = 0; s < SYMS; s++)
            begin
                case (nib_d)
                    4'h0: pw_d[15:12] = din_data[s*IN_BPS +: `VPP_NIB_BITS];
                    4'h1: pw_d[11:8]  = din_data[s*IN_BPS +: `VPP_NIB_BITS];
                    4'h2: pw_d[7:4]   = din_data[s*IN_BPS +: `VPP_NIB_BITS];
                    4'h3: pw_d[3:0]   = din_data[s*IN_BPS +: `VPP_NIB_BITS];
                    4'h4: ph_d[15:12] = din_data[s*IN_BPS +: `VPP_NIB_BITS];
                    4'h5: ph_d[11:8]  = din_data[s*IN_BPS +: `VPP_NIB_BITS];
                    4'h6: ph_d[7:4]   = din_data[s*IN_BPS +: `VPP_NIB_BITS];
                    4'h7: ph_d[3:0]   = din_data[s*IN_BPS +: `VPP_NIB_BITS];
                    4'h8: pi_d        = din_data[s*IN_BPS +: `VPP_NIB_BITS];
                    default: ;
                endcase
                if (nib_d < `VPP_NIB_TOTAL)
                    nib_d = nib_d + 4'h1;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            nib_q <= 4'h0;
            pw_q  <= 16'h0000;
            ph_q  <= 16'h0000;
            pi_q  <= 4'h0;
        end
        else if (accept && din_sop)
            nib_q <= 4'h0;
        else
        begin
            nib_q <= nib_d;
            pw_q  <= pw_d;
            ph_q  <= ph_d;
            pi_q  <= pi_d;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pend_q   <= 1'b0;
            pend_w_q <= 16'h0000;
            pend_h_q <= 16'h0000;
            pend_i_q <= 4'h0;
        end
        else if (body && din_eop && kind_q == KIND_CTRL && nib_d == `VPP_NIB_TOTAL)
        begin
            pend_q   <= 1'b1;
            pend_w_q <= pw_d;
            pend_h_q <= ph_d;
            pend_i_q <= pi_d;
        end
        else if (accept && din_sop && kind_now == KIND_VIDEO)
            pend_q <= 1'b0;
    end

    // Missing control: keep settings, flip field bit 2 when bit 3 is set
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            act_w_q <= 16'h0000;
            act_h_q <= 16'h0000;
            act_i_q <= 4'h0;
        end
        else if (accept && din_sop && kind_now == KIND_VIDEO)
        begin
            if (pend_q)
            begin
                act_w_q <= pend_w_q;
                act_h_q <= pend_h_q;
                act_i_q <= pend_i_q;
            end
            else if (act_i_q[3])
                act_i_q[2] <= ~act_i_q[2];
        end
    end

    always_comb
    begin
        hist_d   = hist_q;
        anc_hits = 16'h0000;
        if (body && kind_q == KIND_ANC)
        begin
            for (int s = 0; s < SYMS; s++)
            begin
                if (32'(din_data[s*IN_BPS +: IN_BPS]) == `VPP_ANC_CODE1 && hist_d == 2'd2)
                begin
                    anc_hits = anc_hits + 16'h0001;
                    hist_d   = 2'd0;
                end
                else if (32'(din_data[s*IN_BPS +: IN_BPS]) == `VPP_ANC_CODE1 && hist_d == 2'd1)
                    hist_d = 2'd2;
                else if (32'(din_data[s*IN_BPS +: IN_BPS]) == `VPP_ANC_CODE0)
                    hist_d = 2'd1;
                else
                    hist_d = 2'd0;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            hist_q <= 2'd0;
        else if (accept && din_sop)
            hist_q <= 2'd0;
        else
            hist_q <= hist_d;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            vid_cnt_q  <= 16'h0000;
            ctl_cnt_q  <= 16'h0000;
            anc_cnt_q  <= 16'h0000;
            oth_cnt_q  <= 16'h0000;
            miss_cnt_q <= 16'h0000;
        end
        else
        begin
            anc_cnt_q <= anc_cnt_q + anc_hits;
            if (accept && din_sop)
            begin
                case (kind_now)
                    KIND_VIDEO:
                    begin
                        vid_cnt_q <= vid_cnt_q + 16'h0001;
                        if (!pend_q)
                            miss_cnt_q <= miss_cnt_q + 16'h0001;
                    end
                    KIND_CTRL: ctl_cnt_q <= ctl_cnt_q + 16'h0001;
                    KIND_ANC, KIND_OTHER: oth_cnt_q <= oth_cnt_q + 16'h0001;
                    default: ;
                endcase
            end
        end
    end

    // APB: one wait state, write lands on the edge that sees pready
    assign bus_do = psel & penable & pready;

    always_comb
    begin
        bus_hit = 1'b1;
        bus_rd  = 32'h0000_0000;
        case (paddr)
            `VPP_OFF_CTRL:    bus_rd[`VPP_CTRL_EN_BIT] = ctrl_en_q;
            `VPP_OFF_GAP:     bus_rd[15:0] = gap_cfg_q;
            `VPP_OFF_STATUS:
            begin
                bus_rd[`VPP_ST_INPKT_BIT] = kind_q != KIND_IDLE;
                bus_rd[`VPP_ST_PEND_BIT]  = pend_q;
                bus_rd[`VPP_ST_KIND_LSB +: 3] = kind_q;
                bus_rd[`VPP_ST_LEVEL_LSB +: CW] = count_q;
            end
            `VPP_OFF_WIDTH:   bus_rd[15:0] = act_w_q;
            `VPP_OFF_HEIGHT:  bus_rd[15:0] = act_h_q;
            `VPP_OFF_INTL:    bus_rd[3:0]  = act_i_q;
            `VPP_OFF_VIDCNT:  bus_rd[15:0] = vid_cnt_q;
            `VPP_OFF_CTLCNT:  bus_rd[15:0] = ctl_cnt_q;
            `VPP_OFF_ANCCNT:  bus_rd[15:0] = anc_cnt_q;
            `VPP_OFF_OTHCNT:  bus_rd[15:0] = oth_cnt_q;
            `VPP_OFF_MISSCNT: bus_rd[15:0] = miss_cnt_q;
            default:          bus_hit = 1'b0;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end
        else
        begin
            pready  <= psel & penable & ~pready;
            pslverr <= psel & penable & ~pready & ~bus_hit;
            if (psel && penable && !pready && !pwrite)
                prdata <= bus_rd;
        end
    end

    // Enable low drains the buffer but stops new beats
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ctrl_en_q <= `VPP_CTRL_RST;
            gap_cfg_q <= `VPP_GAP_RST;
        end
        else if (bus_do && pwrite)
        begin
            if (paddr == `VPP_OFF_CTRL)
                ctrl_en_q <= pwdata[`VPP_CTRL_EN_BIT];
            if (paddr == `VPP_OFF_GAP)
                gap_cfg_q <= pwdata[15:0];
        end
    end
endmodule : vpp_packet_port

// [testbench/vpp_packet_port_asserts.sv]
// Protocol checker for the video packet port
`timescale 1ns/1ps
module vpp_port_chk #(
    parameter int         IN_BPS   = 10,
    parameter int         SYMS     = 2,
    parameter logic [3:0] ANC_TYPE = 4'hc
) (
    input wire logic                   clk,
    input wire logic                   rst_n,
    input wire logic                   psel,
    input wire logic                   penable,
    input wire logic                   pwrite,
    input wire logic [31:0]            prdata,
    input wire logic                   pready,
    input wire logic                   pslverr,
    input wire logic                   din_valid,
    input wire logic [IN_BPS*SYMS-1:0] din_data,
    input wire logic                   din_sop,
    input wire logic                   din_eop,
    input wire logic                   din_ready,
    input wire logic                   dout_valid,
    input wire logic                   dout_sop,
    input wire logic                   dout_eop,
    input wire logic                   dout_ready,
    input wire vpp_pkg::vpp_kind_t     pkt_kind
);
    import vpp_pkg::*;
    logic rdy_q;
    logic busy_q;
    logic acc;
    logic [3:0] ty;
    assign acc = din_valid && rdy_q;
    assign ty = din_data[3:0];
    always_ff @(posedge clk or negedge rst_n)
        if (!rst_n) rdy_q <= 1'h0;
        else rdy_q <= din_ready;
    // Output packet framing seen so far
    always_ff @(posedge clk or negedge rst_n)
        if (!rst_n) busy_q <= 1'h0;
        else if (dout_valid) busy_q <= !dout_eop;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_out_latency: assert property (dout_valid |-> $past(dout_ready))
        else $error("output beat without ready the cycle before");
    a_kind_video: assert property (acc && din_sop && ty == 4'h0 |-> ##[1:2] pkt_kind == KIND_VIDEO)
        else $error("video type not recognised");
    a_kind_ctrl: assert property (acc && din_sop && ty == 4'hf |-> ##[1:2] pkt_kind == KIND_CTRL)
        else $error("control type not recognised");
    a_kind_anc: assert property (acc && din_sop && ty == ANC_TYPE |-> ##[1:2] pkt_kind == KIND_ANC)
        else $error("ancillary type not recognised");
    a_kind_user: assert property (acc && din_sop && ty != 4'h0 && ty != 4'hf && ty != ANC_TYPE
        |-> ##[1:2] pkt_kind == KIND_OTHER)
        else $error("user type not recognised");
    a_kind_idle: assert property (acc && din_eop ##1 (!din_valid)[*2] |-> pkt_kind == KIND_IDLE)
        else $error("kind not idle after end of packet");
    a_out_sop_first: assert property (dout_valid && !busy_q |-> dout_sop)
        else $error("packet on output does not open with start");
    a_out_sop_mid: assert property (dout_valid && busy_q |-> !dout_sop)
        else $error("start marker inside output packet");
    a_apb_wait: assert property (psel && penable && !pready |=> pready)
        else $error("bus answer not in second access cycle");
    a_apb_err_pulse: assert property (pslverr |-> pready && !$past(pready))
        else $error("bus error outside a single answer cycle");
    a_apb_err_zero: assert property (pslverr && !pwrite |-> prdata == 32'h0)
        else $error("failed read returns nonzero data");
endmodule : vpp_port_chk

bind vpp_packet_port vpp_port_chk #(.IN_BPS(IN_BPS), .SYMS(SYMS), .ANC_TYPE(ANC_TYPE)) i_chk (
    .clk, .rst_n, .psel, .penable, .pwrite, .prdata, .pready, .pslverr, .din_valid, .din_data,
    .din_sop, .din_eop, .din_ready, .dout_valid, .dout_sop, .dout_eop, .dout_ready, .pkt_kind);

// [testbench/vpp_sink_model.sv]
// Downstream sink model that stalls at random and records beats
`timescale 1ns/1ps
module vpp_sink_model #(
    parameter int W = 20
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic         stall,
    input  wire logic         dout_valid,
    input  wire logic [W-1:0] dout_data,
    input  wire logic         dout_sop,
    input  wire logic         dout_eop,
    output logic              dout_ready
);
    logic [W+1:0] got_q[$];
    always @(posedge clk or negedge rst_n)
        if (!rst_n) dout_ready <= 1'h0;
        else dout_ready <= !stall || ($urandom_range(2) == 0);
    // markers and data only with valid
    always @(posedge clk)
        if (rst_n && dout_valid) got_q.push_back({dout_sop, dout_eop, dout_data});
endmodule : vpp_sink_model

// [testbench/vpp_packet_port_tb_top.sv]
// Self-checking bench for the video packet port
`timescale 1ns/1ps
`include "vpp_map.svh"
module vpp_packet_port_tb_top;
    import vpp_pkg::*;
    localparam int W = 20;
    logic         clk = 1'h0;
    logic         rst_n = 1'h0;
    logic         psel = 1'h0;
    logic         penable = 1'h0;
    logic         pwrite = 1'h0;
    logic [11:0]  paddr = 12'h0;
    logic [31:0]  pwdata = 32'h0;
    logic [31:0]  prdata;
    logic         pready;
    logic         pslverr;
    logic         din_valid = 1'h0;
    logic [W-1:0] din_data = 20'h0;
    logic         din_sop = 1'h0;
    logic         din_eop = 1'h0;
    logic         din_ready;
    logic         dout_valid;
    logic [W-1:0] dout_data;
    logic         dout_sop;
    logic         dout_eop;
    logic         dout_ready;
    logic         stall = 1'h0;
    vpp_kind_t    pkt_kind;
    int           failures = 0;
    int           compares = 0;
    logic [W+1:0] exp_q[$];
    logic [9:0]   sy[$];
    logic [31:0]  rd;
    logic         er;

    always #4 clk = ~clk;

    vpp_packet_port i_dut (.clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .din_valid, .din_data, .din_sop, .din_eop, .din_ready, .dout_valid, .dout_data,
        .dout_sop, .dout_eop, .dout_ready, .pkt_kind);
    vpp_sink_model #(.W(W)) i_sink (.clk, .rst_n, .stall, .dout_valid, .dout_data, .dout_sop,
        .dout_eop, .dout_ready);

    task automatic close_out;
        if (failures == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : close_out

    task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
        compares++;
        if (got !== ex)
        begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", nm, ex, got);
        end
    endtask : chk

    // Request held until pready is seen at an edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        @(posedge clk);
        psel <= 1'h1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'h1;
        do @(posedge clk); while (pready !== 1'h1);
        rd = prdata;
        er = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask : apb

    task automatic rdchk(input string nm, input logic [11:0] a, input logic [31:0] ex);
        apb(1'h0, a, 32'h0);
        chk(nm, ex, rd);
    endtask : rdchk

    task automatic gap(input int n);
        repeat (n) @(posedge clk) din_valid <= 1'h0;
    endtask : gap

    // Beat only after ready was seen, with random idle cycles
    task automatic beat(input logic [W-1:0] d, input logic s, input logic e);
        @(posedge clk);
        while (din_ready !== 1'h1 || $urandom_range(3) == 0)
        begin
            din_valid <= 1'h0;
            @(posedge clk);
        end
        din_valid <= 1'h1;
        din_data <= d;
        din_sop <= s;
        din_eop <= e;
        exp_q.push_back({s, e, d});
    endtask : beat

    // type beat first, symbol 0 low, end on last
    task automatic pkt(input logic [3:0] ty);
        beat({16'h0, ty}, 1'h1, sy.size() == 0);
        for (int i = 0; i < sy.size(); i += 2)
            beat({(i + 1 < sy.size()) ? sy[i+1] : 10'h0, sy[i]}, 1'h0, i + 2 >= sy.size());
        sy.delete();
        gap(1);
    endtask : pkt

    // nibbles in low bits, upper bits random
    task automatic ctl(input logic [15:0] w, input logic [15:0] h, input logic [3:0] il);
        logic [35:0] nb;
        nb = {w, h, il};
        for (int k = 8; k >= 0; k--)
            sy.push_back({6'($urandom), nb[k*4 +: 4]});
        pkt(4'hf);
    endtask : ctl

    task automatic vid(input int n);
        repeat (2 * n) sy.push_back(10'($urandom));
        pkt(4'h0);
    endtask : vid

    initial
    begin
        #(8 * 20000);
        failures++;
        close_out();
    end

    initial
    begin
        logic [15:0] w2;
        logic [15:0] h2;
        logic [3:0]  il;
        int          n;
        void'($urandom(44129));
        repeat (3) @(posedge clk);
        rst_n <= 1'h1;
        rdchk("ctrl reset", `VPP_OFF_CTRL, 32'h1);
        rdchk("gap reset", `VPP_OFF_GAP, 32'h0);
        apb(1'h0, 12'h02c, 32'h0);
        chk("unmapped error", 32'h1, {31'h0, er});
        chk("unmapped data", 32'h0, rd);
        stall <= 1'h1;
        w2 = 16'($urandom);
        h2 = 16'($urandom);
        il = 4'h8 | 4'($urandom_range(3));
        ctl(16'($urandom), 16'($urandom), 4'h0);
        ctl(w2, h2, il);
        sy = '{10'h0, 10'h3ff, 10'h3ff, 10'h5, 10'h0, 10'h3ff, 10'h3ff, 10'h7};
        pkt(4'hc);
        for (int t = 1; t < 15; t++)
            if (t != 12)
            begin
                n = $urandom_range(5, 1);
                sy.push_back(10'(n));
                repeat (n) sy.push_back(10'($urandom));
                pkt(4'(t));
            end
        vid(3);
        rdchk("width", `VPP_OFF_WIDTH, {16'h0, w2});
        rdchk("height", `VPP_OFF_HEIGHT, {16'h0, h2});
        rdchk("interlace", `VPP_OFF_INTL, {28'h0, il});
        apb(1'h1, `VPP_OFF_WIDTH, 32'h0);
        vid(2);
        rdchk("width kept", `VPP_OFF_WIDTH, {16'h0, w2});
        rdchk("field toggle", `VPP_OFF_INTL, {28'h0, il ^ 4'h4});
        rdchk("video count", `VPP_OFF_VIDCNT, 32'h2);
        rdchk("control count", `VPP_OFF_CTLCNT, 32'h2);
        rdchk("marker count", `VPP_OFF_ANCCNT, 32'h2);
        rdchk("other count", `VPP_OFF_OTHCNT, 32'he);
        rdchk("missing count", `VPP_OFF_MISSCNT, 32'h1);
        stall <= 1'h0;
        apb(1'h1, `VPP_OFF_GAP, 32'h5);
        vid(2);
        n = 0;
        while (din_ready === 1'h1 && n < 4)
        begin
            @(posedge clk);
            n++;
        end
        n = 0;
        while (din_ready !== 1'h1 && n < 20)
        begin
            @(posedge clk);
            n++;
        end
        chk("gap cycles", 32'h5, 32'(n));
        apb(1'h1, `VPP_OFF_GAP, 32'h0);
        apb(1'h1, `VPP_OFF_CTRL, 32'h0);
        gap(3);
        chk("ready when off", 32'h0, {31'h0, din_ready});
        @(posedge clk) din_valid <= 1'h1;
        din_data <= 20'($urandom);
        @(posedge clk) din_valid <= 1'h0;
        apb(1'h1, `VPP_OFF_CTRL, 32'h1);
        ctl(16'h0, 16'h0, 4'h0);
        vid(1);
        repeat (40) @(posedge clk);
        chk("beat count", 32'(exp_q.size()), 32'(i_sink.got_q.size()));
        foreach (exp_q[i])
            if (i < i_sink.got_q.size())
                chk("beat", 32'(exp_q[i]), 32'(i_sink.got_q[i]));
        rdchk("status idle", `VPP_OFF_STATUS, 32'h0);
        close_out();
    end
endmodule : vpp_packet_port_tb_top
